//--- hdl/ipl_top.sv
// ipl_top: reset and interrupt priority, wait, stop and slow mode control
// assumes the core signals instruction boundaries and wait/stop opcodes
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module ipl_top
  import ipl_pkg::*;
#(
  parameter int OSC_STAB_CYCLES = OSC_STAB_DEFAULT
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_por,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  output logic [1:0]       o_avs_response,
  // pins
  input  wire logic        i_irq_n,
  input  wire logic        i_nonmaskable_request_pin_n,
  input  wire logic        i_reset_pin_n,
  // core status
  input  wire logic        i_inst_boundary,
  input  wire logic        i_wait_instruction,
  input  wire logic        i_stop_instruction,
  input  wire logic        i_stack_done,
  input  wire logic        i_ccr_i,
  input  wire logic        i_ccr_x,
  input  wire logic        i_ccr_s,
  input  wire logic        i_special_mode,
  input  wire logic        i_irq_edge_pending,
  // sources
  input  wire logic        i_clkmon_fail,
  input  wire logic        i_watchdog_fail,
  input  wire logic        i_watchdog_disable,
  input  wire logic        i_illegal_op,
  input  wire logic        i_software_trap,
  input  wire logic [14:0] i_mask_req,
  // results
  output logic             o_nmi_take,
  output logic [2:0]       o_nmi_src,
  output logic             o_mask_take,
  output logic [3:0]       o_mask_src,
  output logic             o_clkmon_reset,
  // clocking and power
  output logic             o_core_ce,
  output logic             o_timer_run,
  output logic             o_osc_run,
  output logic             o_core_halt,
  output logic             o_stack_read,
  output logic             o_wake_resume
);
  import ipl_pkg::*;

  typedef enum logic [2:0] {
    IPL_RUN, IPL_WAIT, IPL_STOP, IPL_STAB
  } ipl_state_t;

  // ==========================================================
  // pin synchronisers
  logic [1:0] irq_s_q;
  logic [1:0] nonmaskable_request_pin_s_q;
  logic [1:0] rstp_s_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      irq_s_q  <= 2'h3;
      nonmaskable_request_pin_s_q <= 2'h3;
      rstp_s_q <= 2'h3;
    end else begin
      irq_s_q  <= {irq_s_q[0], i_irq_n};
      nonmaskable_request_pin_s_q <= {nonmaskable_request_pin_s_q[0], i_nonmaskable_request_pin_n};
      rstp_s_q <= {rstp_s_q[0], i_reset_pin_n};
    end
  end

  logic irq_low;
  logic nonmaskable_request_pin_low;
  logic rstp_low;
  assign irq_low  = !irq_s_q[1];
  assign nonmaskable_request_pin_low = !nonmaskable_request_pin_s_q[1];
  assign rstp_low = !rstp_s_q[1];

  // ==========================================================
  // registers
  logic [4:0] promote_q;
  logic [7:0] options_q;
  logic       slow_q;
  logic [6:0] boot_cnt_q;
  logic       opt_written_q;
  logic       por_seen_q;
  logic       ack_q;

  logic       bus_wr;
  logic       stop_entry;
  logic       boot_window;
  // writes land only on the accepting edge
  assign bus_wr      = i_avs_write && i_avs_byteenable[0] && ack_q;
  assign boot_window = boot_cnt_q < 7'(WRITE_ONCE_CYCLES);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      promote_q <= PROMOTE_RST;
    end else if (bus_wr && i_avs_address == ADDR_PROMOTE && i_ccr_i) begin
      promote_q <= i_avs_writedata[4:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      boot_cnt_q <= 7'h00;
    end else if (boot_window) begin
      boot_cnt_q <= boot_cnt_q + 7'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      options_q     <= OPTIONS_RST;
      opt_written_q <= 1'b0;
    end else if (bus_wr && i_avs_address == ADDR_OPTIONS) begin
      if (i_special_mode || (boot_window && !opt_written_q)) begin
        options_q[OPT_DELAY_BIT] <= i_avs_writedata[OPT_DELAY_BIT];
        opt_written_q            <= 1'b1;
      end
      options_q[OPT_CME_BIT]  <= i_avs_writedata[OPT_CME_BIT];
      options_q[OPT_FORCED_CLOCK_MONITOR_ENABLE_BIT] <= i_avs_writedata[OPT_FORCED_CLOCK_MONITOR_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || stop_entry) begin
      slow_q <= 1'b0;
    end else if (bus_wr && i_avs_address == ADDR_OPTIONS3) begin
      slow_q <= i_avs_writedata[SYSTEM_OPTIONS_THREE_SLOW_BIT];
    end
  end

  // ==========================================================
  // avalon answer: one wait cycle then data
  ipl_state_t state_q;
  logic       mapped;
  assign mapped = i_avs_address == ADDR_PROMOTE || i_avs_address == ADDR_OPTIONS ||
                  i_avs_address == ADDR_OPTIONS3 || i_avs_address == ADDR_STATUS;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
      o_avs_response <= 2'h0;
    end else if (i_avs_read && !ack_q) begin
      o_avs_response <= mapped ? 2'h0 : 2'h2;
      case (i_avs_address)
        ADDR_PROMOTE:  o_avs_readdata <= {27'h0, promote_q};
        ADDR_OPTIONS:  o_avs_readdata <= {24'h0, options_q};
        ADDR_OPTIONS3: o_avs_readdata <= {31'h0, slow_q};
        ADDR_STATUS:   o_avs_readdata <= {28'h0, por_seen_q, state_q};
        default:       o_avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // priority resolution
  logic [14:0] mask_gated;
  logic        mask_valid;
  logic [3:0]  mask_idx;
  assign mask_gated = i_ccr_i ? 15'h0000 : i_mask_req;

  ipl_mask_resolver u_res (
    .i_req     (mask_gated),
    .i_promote (promote_q),
    .o_valid   (mask_valid),
    .o_index   (mask_idx)
  );

  ipl_nmi_t nmi_win;
  logic     nonmaskable_request_pin_req;
  assign nonmaskable_request_pin_req = nonmaskable_request_pin_low && !i_ccr_x;

  always_comb begin
    if (i_rst || rstp_low) begin
      nmi_win = IPL_NMI_RESET;
    end else if (i_clkmon_fail || o_clkmon_reset) begin
      nmi_win = IPL_NMI_CLKMON;
    end else if (i_watchdog_fail) begin
      nmi_win = IPL_NMI_WDOG;
    end else if (nonmaskable_request_pin_req) begin
      nmi_win = IPL_NMI_PIN;
    end else if (i_illegal_op) begin
      nmi_win = IPL_NMI_ILLOP;
    end else if (i_software_trap) begin
      nmi_win = IPL_NMI_TRAP;
    end else begin
      nmi_win = IPL_NMI_NONE;
    end
  end

  logic boundary;
  assign boundary = i_inst_boundary || (state_q == IPL_WAIT);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_nmi_take  <= 1'b0;
      o_nmi_src   <= 3'h0;
      o_mask_take <= 1'b0;
      o_mask_src  <= 4'h0;
    end else begin
      o_nmi_take  <= boundary && nmi_win != IPL_NMI_NONE;
      o_nmi_src   <= nmi_win;
      o_mask_take <= boundary && nmi_win == IPL_NMI_NONE && mask_valid;
      o_mask_src  <= mask_idx;
    end
  end

  // ==========================================================
  // low-power sequencing
  logic [12:0] stab_cnt_q;
  logic        stop_wake;
  logic        stop_go;
  assign stop_go    = i_stop_instruction && i_inst_boundary && state_q == IPL_RUN;
  assign stop_entry = stop_go && !i_ccr_s;
  assign stop_wake  = rstp_low || nonmaskable_request_pin_low || (!i_ccr_i && (irq_low || i_irq_edge_pending));

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      por_seen_q <= 1'b0;
    end else begin
      por_seen_q <= i_por ? 1'b1 : (state_q == IPL_RUN ? 1'b0 : por_seen_q);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_q    <= IPL_RUN;
      stab_cnt_q <= 13'h0000;
    end else begin
      case (state_q)
        IPL_RUN: begin
          if (i_por) begin
            state_q    <= IPL_STAB;
            stab_cnt_q <= 13'h0000;
          end else if (stop_entry) begin
            state_q <= IPL_STOP;
          end else if (i_wait_instruction && i_stack_done) begin
            state_q <= IPL_WAIT;
          end
        end
        IPL_WAIT: begin
          if (nmi_win != IPL_NMI_NONE || mask_valid) begin
            state_q <= IPL_RUN;
          end
        end
        IPL_STOP: begin
          if (stop_wake) begin
            stab_cnt_q <= 13'h0000;
            state_q    <= options_q[OPT_DELAY_BIT] ? IPL_STAB : IPL_RUN;
          end
        end
        IPL_STAB: begin
          stab_cnt_q <= stab_cnt_q + 13'h0001;
          if (stab_cnt_q == 13'(OSC_STAB_CYCLES - 1)) begin
            state_q <= IPL_RUN;
          end
        end
        default: state_q <= IPL_RUN;
      endcase
    end
  end

  // clock monitor reset if armed at stop entry
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_clkmon_reset <= 1'b0;
    end else begin
      o_clkmon_reset <= stop_entry && (options_q[OPT_CME_BIT] || options_q[OPT_FORCED_CLOCK_MONITOR_ENABLE_BIT]);
    end
  end

  // masked nonmaskable pin resumes after the stop opcode
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_wake_resume <= 1'b0;
    end else begin
      o_wake_resume <= state_q == IPL_STOP && stop_wake && !rstp_low;
    end
  end

  logic run_en;
  assign run_en       = state_q == IPL_RUN;
  assign o_osc_run    = state_q != IPL_STOP;
  assign o_core_halt  = !run_en;
  assign o_stack_read = state_q == IPL_WAIT;
  assign o_timer_run  = state_q == IPL_RUN || state_q == IPL_STAB ||
                        (state_q == IPL_WAIT && !(i_ccr_i && i_watchdog_disable));

  ipl_slow_div u_div (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_slow (slow_q),
    .i_run  (run_en),
    .o_ce   (o_core_ce)
  );
endmodule

//--- hdl/ipl_pkg.sv
// ipl_pkg: shared constants for the interrupt priority and low-power block
// assumes one 25 MHz clock, registers reached over avalon-mm
package ipl_pkg;
  // ==========================================================
  // register map (word offsets as byte addresses)
  localparam logic [3:0] ADDR_PROMOTE   = 4'h0;
  localparam logic [3:0] ADDR_OPTIONS   = 4'h4;
  localparam logic [3:0] ADDR_OPTIONS3  = 4'h8;
  localparam logic [3:0] ADDR_STATUS    = 4'hC;
  // ==========================================================
  // field positions and reset values
  localparam int OPT_DELAY_BIT   = 4;
  localparam int OPT_CME_BIT     = 3;
  localparam int OPT_FORCED_CLOCK_MONITOR_ENABLE_BIT    = 0;
  localparam int SYSTEM_OPTIONS_THREE_SLOW_BIT   = 0;
  localparam logic [4:0] PROMOTE_RST = 5'h06;
  localparam logic [7:0] OPTIONS_RST = 8'h10;
  // ==========================================================
  // counts
  localparam int WRITE_ONCE_CYCLES = 64;
  localparam int SLOW_DIV          = 16;
  localparam int OSC_STAB_DEFAULT  = 4064;
  localparam int NUM_MASK_SRC      = 15;
  localparam logic [4:0] CODE_FIRST = 5'h06;
  localparam logic [4:0] CODE_LAST  = 5'h14;
  // ==========================================================
  // winners of the non-maskable ladder
  typedef enum logic [2:0] {
    IPL_NMI_NONE, IPL_NMI_RESET, IPL_NMI_CLKMON, IPL_NMI_WDOG,
    IPL_NMI_PIN, IPL_NMI_ILLOP, IPL_NMI_TRAP
  } ipl_nmi_t;
endpackage

//--- hdl/ipl_mask_resolver.sv
// ipl_mask_resolver: picks one maskable winner, promoted source first
// assumes requests already gated by local enables and the inhibit bit
`timescale 1ns/1ps
module ipl_mask_resolver
  import ipl_pkg::*;
(
  // requests
  input  wire logic [14:0] i_req,
  input  wire logic [4:0]  i_promote,
  // result
  output logic             o_valid,
  output logic [3:0]       o_index
);
  logic [3:0] prom_idx;
  logic [3:0] dflt_idx;
  logic       dflt_hit;

  // reserved codes fall back to the external pin
  always_comb begin
    if (i_promote >= CODE_FIRST && i_promote <= CODE_LAST) begin
      prom_idx = 4'(i_promote - CODE_FIRST);
    end else begin
      prom_idx = 4'h0;
    end
  end

  // default order: index 0 highest
  always_comb begin
    dflt_idx = 4'h0;
    dflt_hit = 1'b0;
    for (int k = NUM_MASK_SRC - 1; k >= 0; k--) begin
      if (i_req[k]) begin
        dflt_idx = 4'(k);
        dflt_hit = 1'b1;
      end
    end
  end

  // promoted wins only if it is itself requesting
  assign o_valid = dflt_hit;
  assign o_index = i_req[prom_idx] ? prom_idx : dflt_idx;
endmodule

//--- hdl/ipl_slow_div.sv
// ipl_slow_div: one-cycle enable pulses for the core clock
// assumes i_mclk is the oscillator rate
`timescale 1ns/1ps
module ipl_slow_div
  import ipl_pkg::*;
(
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // control
  input  wire logic i_slow,
  input  wire logic i_run,
  // output
  output logic      o_ce
);
  logic [3:0] cnt_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst || !i_slow) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // divide by 16 when slow, every cycle otherwise
  assign o_ce = i_run && (!i_slow || cnt_q == 4'(SLOW_DIV - 1));
endmodule

//--- tb/ipl_top_sva.sv
// ipl_top_sva: port-level checks on ipl_top
// assumes one clock domain with sync active-high reset
`timescale 1ns/1ps
module ipl_top_sva (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_inst_boundary,
  input wire logic        i_stop_instruction,
  input wire logic        i_ccr_i,
  input wire logic        i_ccr_s,
  input wire logic        i_watchdog_disable,
  input wire logic        i_clkmon_fail,
  input wire logic [14:0] i_mask_req,
  input wire logic        o_nmi_take,
  input wire logic [2:0]  o_nmi_src,
  input wire logic        o_mask_take,
  input wire logic [3:0]  o_mask_src,
  input wire logic        o_core_ce,
  input wire logic        o_timer_run,
  input wire logic        o_osc_run,
  input wire logic        o_core_halt,
  input wire logic        o_stack_read
);
  logic [14:0] req_q;
  always_ff @(posedge i_mclk) begin
    req_q <= i_mask_req;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_stop_nop;
    i_inst_boundary && i_stop_instruction && i_ccr_s && o_osc_run;
  endsequence
  // ==========================================================
  // priority and timing
  nmi_rank_a: assert property (o_nmi_take && o_nmi_src == 3'h3 |-> !$past(i_clkmon_fail))
    else $error("watchdog outranked clock monitor");
  mask_bnd_a: assert property (o_mask_take |-> $past(i_inst_boundary) || $past(o_stack_read))
    else $error("maskable taken off boundary");
  mask_pend_a: assert property (o_mask_take |-> req_q[o_mask_src])
    else $error("winner was not pending");
  mask_inhib_a: assert property (o_mask_take |-> !$past(i_ccr_i))
    else $error("maskable taken while inhibited");
  one_win_a: assert property (!(o_mask_take && o_nmi_take))
    else $error("two winners at once");
  // ==========================================================
  // low power
  halt_ce_a: assert property (o_core_halt |-> !o_core_ce)
    else $error("core enabled while halted");
  wait_osc_a: assert property (o_stack_read |-> o_osc_run)
    else $error("oscillator off in wait");
  timer_gate_a: assert property (o_stack_read |-> o_timer_run == !(i_ccr_i && i_watchdog_disable))
    else $error("timer gating wrong in wait");
  stop_nop_a: assert property (s_stop_nop |=> o_osc_run [*3])
    else $error("stop acted with stop disabled");
endmodule
bind ipl_top ipl_top_sva ipl_top_sva_inst (.*);

//--- tb/ipl_core_model.sv
// ipl_core_model: core stand-in making instruction boundaries and stacking
// assumes the block's core enable paces instructions, three enables each
`timescale 1ns/1ps
module ipl_core_model (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst,
  // from block
  input  wire logic i_ce,
  input  wire logic i_wait,
  // to block
  output logic      o_boundary,
  output logic      o_stack_done
);
  logic [1:0] cnt_q;
  logic       pend_q;
  // ==========================================================
  // instruction pacing
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_q      <= 2'h0;
      o_boundary <= 1'h0;
    end else begin
      o_boundary <= i_ce && cnt_q == 2'h2;
      if (i_ce) begin
        cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      end
    end
  end
  // ==========================================================
  // stacking ends two cycles after a wait boundary
  always_ff @(posedge i_mclk) begin
    if (i_rst || (o_boundary && !i_wait)) begin
      pend_q <= 1'h0;
    end else if (o_boundary) begin
      pend_q <= 1'h1;
    end
    o_stack_done <= pend_q;
  end
endmodule

//--- tb/ipl_top_tb.sv
// ipl_top_tb: self-checking bench for ipl_top beside a core stand-in
// assumes 25 MHz clock and a stabilization count cut to 8
`timescale 1ns/1ps
module ipl_top_tb;
  import ipl_pkg::*;
  logic i_mclk = 0, i_rst = 1, i_por = 0, i_avs_read = 0, i_avs_write = 0, o_avs_waitrequest;
  logic [3:0] i_avs_address = 4'h0, i_avs_byteenable = 4'hF, o_mask_src;
  logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
  logic [1:0] o_avs_response, rsp;
  logic i_irq_n = 1, i_nonmaskable_request_pin_n = 1, i_reset_pin_n = 1, i_inst_boundary, i_stack_done;
  logic i_wait_instruction = 0, i_stop_instruction = 0, i_ccr_i = 1, i_ccr_x = 1, i_ccr_s = 1;
  logic i_special_mode = 0, i_irq_edge_pending = 0, i_clkmon_fail = 0, i_watchdog_fail = 0;
  logic i_watchdog_disable = 0, i_illegal_op = 0, i_software_trap = 0;
  logic [14:0] i_mask_req = 15'h0;
  logic o_nmi_take, o_mask_take, o_clkmon_reset, o_core_ce, o_timer_run, o_osc_run;
  logic o_core_halt, o_stack_read, o_wake_resume;
  logic [2:0] o_nmi_src;
  int bad_count = 0, n_compared = 0, k;
  ipl_top #(.OSC_STAB_CYCLES(8)) ipl_top_inst (.*);
  ipl_core_model ipl_core_model_inst (.i_mclk, .i_rst, .i_ce(o_core_ce), .i_wait(i_wait_instruction),
                                      .o_boundary(i_inst_boundary), .o_stack_done(i_stack_done));
  always #20 i_mclk = ~i_mclk;
  // ==========================================================
  // shared tasks
  task automatic close_out;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_address <= a;
    i_avs_writedata <= {24'h0, d};
    i_avs_read <= !wr;
    i_avs_write <= wr;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 20);
    rd = o_avs_readdata;
    rsp = o_avs_response;
    i_avs_read <= 0;
    i_avs_write <= 0;
    chk(n < 20, 1);
    if (n >= 20) close_out();
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return o_mask_take;
      1: return o_nmi_take;
      2: return !o_osc_run;
      3: return o_osc_run;
      4: return o_core_ce;
      5: return o_clkmon_reset;
      6: return o_stack_read;
      default: return o_wake_resume;
    endcase
  endfunction
  task automatic wait_for(input int w, input int lim);
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (sig(w) !== 1'b1 && k < lim);
    if (sig(w) !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: wait %0d ran out", $time, w);
      close_out();
    end
  endtask
  task automatic quiet(input int w, input int n);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge i_mclk);
      c += (sig(w) === 1'b1);
    end
    chk(c, 0);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    bus(0, ADDR_OPTIONS, 8'h0);
    chk(rd, 32'h10);
    bus(0, ADDR_OPTIONS3, 8'h0);
    chk(rd, 32'h0);
    bus(0, ADDR_PROMOTE, 8'h0);
    chk(rd[4:0], 5'h06);
    bus(0, 4'h2, 8'h0);
    chk(rsp, 2'h2);
    bus(1, ADDR_OPTIONS, 8'h0);
    bus(1, ADDR_OPTIONS, 8'h10);
    bus(0, ADDR_OPTIONS, 8'h0);
    chk(rd[4], 0);
    $display("regs done");
  endtask
  task automatic t_promote;
    for (int n = 0; n < 32; n++) begin
      i_ccr_i <= 1;
      bus(1, ADDR_PROMOTE, n[7:0]);
      i_ccr_i <= 0;
      i_mask_req <= 15'h7FFF;
      wait_for(0, 40);
      chk(o_mask_src, (n >= CODE_FIRST && n <= CODE_LAST) ? n - CODE_FIRST : 0);
      i_mask_req <= 15'h0;
    end
    bus(1, ADDR_PROMOTE, 8'h0A);
    bus(0, ADDR_PROMOTE, 8'h0);
    chk(rd[4:0], 5'h1F);
    i_ccr_i <= 1;
    bus(1, ADDR_PROMOTE, 8'h0A);
    i_mask_req <= 15'h0010;
    quiet(0, 20);
    i_ccr_i <= 0;
    wait_for(0, 40);
    chk(o_mask_src, 4'h4);
    i_mask_req <= 15'h0;
    i_ccr_i <= 1;
    bus(1, ADDR_PROMOTE, 8'h06);
    i_ccr_i <= 0;
    for (int s = 0; s < NUM_MASK_SRC; s++) begin
      i_mask_req <= 15'h7FFF << s;
      wait_for(0, 40);
      chk(o_mask_src, s);
    end
    i_mask_req <= 15'h0;
    $display("maskable done");
  endtask
  task automatic t_nmi;
    logic [4:0] v;
    i_ccr_x <= 0;
    i_mask_req <= 15'h0001;
    for (int i = 0; i < 5; i++) begin
      v = 5'h1F >> i;
      {i_clkmon_fail, i_watchdog_fail, i_illegal_op, i_software_trap} <= {v[4:3], v[1:0]};
      i_nonmaskable_request_pin_n <= !v[2];
      repeat (4) @(posedge i_mclk);
      wait_for(1, 40);
      chk(o_nmi_src, i + 2);
    end
    i_software_trap <= 0;
    i_mask_req <= 15'h0;
    $display("nonmaskable done");
  endtask
  task automatic t_wait;
    i_ccr_i <= 0;
    i_watchdog_disable <= 1;
    i_wait_instruction <= 1;
    wait_for(6, 60);
    i_wait_instruction <= 0;
    chk({o_osc_run, o_timer_run, o_core_ce}, 3'h6);
    i_mask_req <= 15'h0002;
    wait_for(0, 40);
    chk(o_mask_src, 4'h1);
    i_mask_req <= 15'h0;
    i_ccr_i <= 1;
    i_wait_instruction <= 1;
    wait_for(6, 60);
    i_wait_instruction <= 0;
    chk(o_timer_run, 0);
    i_nonmaskable_request_pin_n <= 0;
    wait_for(1, 40);
    chk(o_nmi_src, 3'h4);
    i_nonmaskable_request_pin_n <= 1;
    $display("wait done");
  endtask
  task automatic stop_now(input int lim);
    i_stop_instruction <= 1;
    wait_for(2, lim);
    i_stop_instruction <= 0;
  endtask
  task automatic t_stop;
    int c;
    bus(1, ADDR_OPTIONS3, 8'h01);
    c = 0;
    repeat (64) begin
      @(posedge i_mclk);
      c += (o_core_ce === 1'b1);
    end
    chk(c, 4);
    i_stop_instruction <= 1;
    quiet(2, 120);
    i_ccr_s <= 0;
    stop_now(160);
    bus(0, ADDR_OPTIONS3, 8'h0);
    chk(rd[0], 0);
    i_irq_n <= 0;
    quiet(3, 20);
    i_ccr_i <= 0;
    wait_for(3, 40);
    wait_for(4, 7);
    i_irq_n <= 1;
    i_ccr_i <= 1;
    i_ccr_x <= 1;
    stop_now(40);
    i_nonmaskable_request_pin_n <= 0;
    wait_for(7, 40);
    i_nonmaskable_request_pin_n <= 1;
    quiet(1, 12);
    bus(1, ADDR_OPTIONS, 8'h08);
    i_stop_instruction <= 1;
    wait_for(5, 120);
    i_stop_instruction <= 0;
    $display("stop done");
  endtask
  task automatic t_reset;
    bus(1, ADDR_OPTIONS3, 8'h01);
    i_rst <= 1;
    i_por <= 1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 0;
    @(posedge i_mclk);
    i_por <= 0;
    quiet(4, 6);
    wait_for(4, 20);
    bus(0, ADDR_OPTIONS, 8'h0);
    chk(rd[4], 1);
    bus(0, ADDR_OPTIONS3, 8'h0);
    chk(rd[0], 0);
    stop_now(40);
    i_irq_n <= 0;
    i_ccr_i <= 0;
    wait_for(3, 40);
    wait_for(4, 40);
    chk(k >= 8, 1);
    i_irq_n <= 1;
    repeat (3) @(posedge i_mclk);
    stop_now(40);
    quiet(3, 6);
    i_irq_edge_pending <= 1;
    wait_for(3, 40);
    i_irq_edge_pending <= 0;
    $display("reset done");
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    i_rst <= 0;
    t_regs();
    t_promote();
    t_nmi();
    t_wait();
    t_stop();
    t_reset();
    close_out();
  end
endmodule
